// ==== verilog/brf_register_file.v ====
// mode-banked general register file with status words
// assumes datapath and exception logic share core_clk and drive strobes
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "brf_map.vh"

module brf_register_file #(
  parameter DATA_W = 32
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // read port a
  input wire [3:0] rd_a_index,
  output reg [DATA_W-1:0] rd_a_data,
  // read port b
  input wire [3:0] rd_b_index,
  output reg [DATA_W-1:0] rd_b_data,
  // write port
  input wire wr_en,
  input wire [3:0] wr_index,
  input wire [1:0] wr_size,
  input wire [DATA_W-1:0] wr_data,
  // call with link
  input wire link_en,
  input wire [DATA_W-1:0] link_addr,
  // program counter load and advance
  input wire pc_load,
  input wire [DATA_W-1:0] pc_next,
  // status word software access
  input wire sw_wr_en,
  input wire sw_wr_saved,
  input wire [3:0] sw_wr_field_mask,
  input wire [DATA_W-1:0] sw_wr_data,
  // exception entry and return
  input wire exc_enter,
  input wire [4:0] exc_mode,
  input wire exc_return,
  // state
  output reg [DATA_W-1:0] current_status_word,
  output reg [DATA_W-1:0] saved_status_word,
  output reg [DATA_W-1:0] pc_value,
  output wire privileged,
  output wire mode_valid,
  output wire has_saved_status
);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  // slots 0..30 of general registers
  reg [DATA_W-1:0] gpr [0:30];
  // saved status words per exception bank 1..5
  reg [DATA_W-1:0] saved_bank [1:5];

  wire [4:0] cur_mode;
  reg [2:0] bank;
  reg saved_ok;
  wire [4:0] slot_a;
  wire [4:0] slot_b;
  wire [4:0] slot_w;
  wire [4:0] slot_l;
  reg [DATA_W-1:0] merged_w;
  reg [DATA_W-1:0] sw_merged;
  reg [DATA_W-1:0] next_status;
  reg [DATA_W-1:0] next_status_src;
  reg [2:0] exc_bank;
  integer i;

  assign cur_mode = current_status_word[`BRF_SW_MODE_HI:`BRF_SW_MODE_LO];

  // ------------------------------------------------------------
  // mode to bank reduction
  // ------------------------------------------------------------
  // bank from the current mode
  always @* begin
    bank = `BRF_BANK_USER;
    saved_ok = 1'b1;
    case (cur_mode)
      `BRF_MODE_FAST: bank = `BRF_BANK_FAST;
      `BRF_MODE_IRQ: bank = `BRF_BANK_IRQ;
      `BRF_MODE_SVC: bank = `BRF_BANK_SVC;
      `BRF_MODE_ABT: bank = `BRF_BANK_ABT;
      `BRF_MODE_UND: bank = `BRF_BANK_UND;
      default: saved_ok = 1'b0;
    endcase
  end

  // bank of the mode being entered
  always @* begin
    case (exc_mode)
      `BRF_MODE_FAST: exc_bank = `BRF_BANK_FAST;
      `BRF_MODE_IRQ: exc_bank = `BRF_BANK_IRQ;
      `BRF_MODE_SVC: exc_bank = `BRF_BANK_SVC;
      `BRF_MODE_ABT: exc_bank = `BRF_BANK_ABT;
      `BRF_MODE_UND: exc_bank = `BRF_BANK_UND;
      default: exc_bank = `BRF_BANK_USER;
    endcase
  end

  // mode status outputs
  assign privileged = (cur_mode != `BRF_MODE_USER);
  assign has_saved_status = saved_ok;
  assign mode_valid = (cur_mode == `BRF_MODE_USER) |
    (cur_mode == `BRF_MODE_SYS) | saved_ok;

  // ------------------------------------------------------------
  // index decoders, only 16 indices reach storage
  // ------------------------------------------------------------
  brf_index_decode u_dec_a (
    .index(rd_a_index),
    .bank(bank),
    .slot(slot_a)
  );

  brf_index_decode u_dec_b (
    .index(rd_b_index),
    .bank(bank),
    .slot(slot_b)
  );

  brf_index_decode u_dec_w (
    .index(wr_index),
    .bank(bank),
    .slot(slot_w)
  );

  brf_index_decode u_dec_l (
    .index(`BRF_IDX_LINK),
    .bank(bank),
    .slot(slot_l)
  );

  // ------------------------------------------------------------
  // write data sizing
  // ------------------------------------------------------------
  // narrow writes zero extend into the low lanes
  always @* begin
    case (wr_size)
      `BRF_SIZE_BYTE: merged_w = {{(DATA_W-8){1'b0}}, wr_data[7:0]};
      `BRF_SIZE_HALF: merged_w = {{(DATA_W-16){1'b0}}, wr_data[15:0]};
      default: merged_w = wr_data;
    endcase
  end

  // ------------------------------------------------------------
  // general register writes
  // ------------------------------------------------------------
  // write port and link capture; the link wins on the same slot
  always @(posedge core_clk) begin
    if (!rst_n) begin
      for (i = 0; i < 31; i = i + 1) begin
        gpr[i] <= {DATA_W{1'b0}};
      end
    end else begin
      if (wr_en && slot_w != 5'h1f) begin
        gpr[slot_w] <= merged_w;
      end
      if (link_en) begin
        gpr[slot_l] <= link_addr;
      end
    end
  end

  // program counter register
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pc_value <= {DATA_W{1'b0}};
    end else if (wr_en && wr_index == `BRF_IDX_PC) begin
      pc_value <= merged_w;
    end else if (pc_load) begin
      pc_value <= pc_next;
    end
  end

  // ------------------------------------------------------------
  // read ports, registered
  // ------------------------------------------------------------
  // read data appear the cycle after the index
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rd_a_data <= {DATA_W{1'b0}};
      rd_b_data <= {DATA_W{1'b0}};
    end else begin
      rd_a_data <= (slot_a == 5'h1f) ? pc_value : gpr[slot_a];
      rd_b_data <= (slot_b == 5'h1f) ? pc_value : gpr[slot_b];
    end
  end

  // ------------------------------------------------------------
  // status word update
  // ------------------------------------------------------------
  // field mask lanes: 3 flags, 0 control byte
  always @* begin
    next_status_src = sw_wr_saved ?
      ((bank >= `BRF_BANK_FAST && saved_ok) ? saved_bank[bank] :
       {DATA_W{1'b0}}) : current_status_word;
    sw_merged = next_status_src;
    if (sw_wr_field_mask[3]) begin
      sw_merged[31:24] = sw_wr_data[31:24];
    end
    if (sw_wr_field_mask[2]) begin
      sw_merged[23:16] = sw_wr_data[23:16];
    end
    if (sw_wr_field_mask[1]) begin
      sw_merged[15:8] = sw_wr_data[15:8];
    end
    if (sw_wr_field_mask[0] && privileged) begin
      sw_merged[7:0] = sw_wr_data[7:0];
    end
    sw_merged = sw_merged & `BRF_SW_MASK;
  end

  // next current status word: entry over return over software write
  always @* begin
    next_status = current_status_word;
    if (exc_enter) begin
      next_status = current_status_word;
      next_status[`BRF_SW_MODE_HI:`BRF_SW_MODE_LO] = exc_mode;
      next_status[`BRF_SW_IRQ_DIS] = 1'b1;
      next_status[`BRF_SW_STATE] = 1'b0;
      if (exc_mode == `BRF_MODE_FAST) begin
        next_status[`BRF_SW_FAST_DIS] = 1'b1;
      end
    end else if (exc_return && saved_ok) begin
      next_status = saved_bank[bank];
    end else if (sw_wr_en && !sw_wr_saved) begin
      next_status = sw_merged;
    end
  end

  // current status word register
  always @(posedge core_clk) begin
    if (!rst_n) begin
      current_status_word <= `BRF_SW_RESET;
    end else begin
      current_status_word <= next_status;
    end
  end

  // saved status words: capture on entry, software write when owned
  always @(posedge core_clk) begin
    if (!rst_n) begin
      for (i = 1; i < 6; i = i + 1) begin
        saved_bank[i] <= {DATA_W{1'b0}};
      end
    end else if (exc_enter) begin
      if (exc_bank != `BRF_BANK_USER) begin
        saved_bank[exc_bank] <= current_status_word;
      end
    end else if (sw_wr_en && sw_wr_saved && saved_ok) begin
      saved_bank[bank] <= sw_merged;
    end
  end

  // saved status read view; reads zero where none exists
  always @(posedge core_clk) begin
    if (!rst_n) begin
      saved_status_word <= {DATA_W{1'b0}};
    end else if (saved_ok) begin
      saved_status_word <= saved_bank[bank];
    end else begin
      saved_status_word <= {DATA_W{1'b0}};
    end
  end

endmodule

// ==== verilog/brf_map.vh ====
// constants for the mode-banked register file
// assumes it is included by name from the register file modules
//
// Function
// - seven modes are supported and the current mode picks the bank.
// - storage is 31 general 32-bit registers plus 6 status registers.
// - exactly 16 general registers are addressable at a time.
// - index 15 is the program counter in every mode.
// - index 14 takes the return address on a call with link.
// - indices 0 to 7 are one shared register each in all modes.
// - indices 8 to 14 select a register that depends on the mode.
// - the mode alone decides what is exposed; other banks are hidden.
// - the mode changes by a mode field write, on exception entry or on exception return.
// - every mode but user is privileged.
// - byte, half-word and word quantities are handled.
// - fast interrupt mode banks 8 to 12 too; others bank only 13, 14.
// - system mode uses the user bank for every index.
// - each exception mode saves the prior status word on entry.
// - status word holds four flags, two masks, state bit, 5-bit mode.
`ifndef BRF_MAP_VH
`define BRF_MAP_VH

// ------------------------------------------------------------
// mode field encodings
// ------------------------------------------------------------
`define BRF_MODE_USER 5'h10
`define BRF_MODE_FAST 5'h11
`define BRF_MODE_IRQ 5'h12
`define BRF_MODE_SVC 5'h13
`define BRF_MODE_ABT 5'h17
`define BRF_MODE_UND 5'h1b
`define BRF_MODE_SYS 5'h1f

// ------------------------------------------------------------
// status word field positions
// ------------------------------------------------------------
`define BRF_SW_N 31
`define BRF_SW_Z 30
`define BRF_SW_C 29
`define BRF_SW_V 28
`define BRF_SW_IRQ_DIS 7
`define BRF_SW_FAST_DIS 6
`define BRF_SW_STATE 5
`define BRF_SW_MODE_HI 4
`define BRF_SW_MODE_LO 0
`define BRF_SW_MASK 32'hf000_00ff

// ------------------------------------------------------------
// reset values and indices
// ------------------------------------------------------------
`define BRF_SW_RESET 32'h0000_00d3
`define BRF_IDX_PC 4'hf
`define BRF_IDX_LINK 4'he
`define BRF_IDX_STACK 4'hd

// ------------------------------------------------------------
// bank numbers for banked indices
// ------------------------------------------------------------
`define BRF_BANK_USER 3'h0
`define BRF_BANK_FAST 3'h1
`define BRF_BANK_IRQ 3'h2
`define BRF_BANK_SVC 3'h3
`define BRF_BANK_ABT 3'h4
`define BRF_BANK_UND 3'h5

// access sizes
`define BRF_SIZE_BYTE 2'h0
`define BRF_SIZE_HALF 2'h1
`define BRF_SIZE_WORD 2'h2

`endif

// ==== verilog/brf_index_decode.v ====
// index decoder: maps a visible register index to a physical slot
// assumes the mode has been reduced to a bank number by the caller
`timescale 1ns/10ps
`include "brf_map.vh"

module brf_index_decode (
  // selection
  input wire [3:0] index,
  input wire [2:0] bank,
  // physical slot 0..30, 31 means the program counter
  output reg [4:0] slot
);

  // ------------------------------------------------------------
  // slot layout
  // ------------------------------------------------------------
  // 0-7 shared, 8-14 user bank, 15-21 fast copies of 8-14,
  // 22-23 irq, 24-25 svc, 26-27 abort, 28-29 undefined, 30 spare
  // combinational lookup of the physical slot
  always @* begin
    slot = {1'b0, index};
    if (index == `BRF_IDX_PC) begin
      slot = 5'h1f;
    end else if (index[3] == 1'b0) begin
      slot = {1'b0, index};
    end else if (bank == `BRF_BANK_FAST) begin
      slot = 5'h0f + {2'h0, index[2:0]};
    end else if (index >= `BRF_IDX_STACK) begin
      case (bank)
        `BRF_BANK_IRQ: slot = 5'h16 + {4'h0, index[0]};
        `BRF_BANK_SVC: slot = 5'h18 + {4'h0, index[0]};
        `BRF_BANK_ABT: slot = 5'h1a + {4'h0, index[0]};
        `BRF_BANK_UND: slot = 5'h1c + {4'h0, index[0]};
        default: slot = {1'b0, index};
      endcase
    end
  end

endmodule

// ==== sim/brf_checker.sv ====
// checker for the banked register file, watching its ports only
// assumes one clock core_clk and synchronous active-low rst_n
`timescale 1ns/10ps
`include "brf_map.vh"
module brf_checker (
  // clock and reset
  input wire core_clk, rst_n,
  // requests
  input wire wr_en, pc_load, exc_enter,
  input wire [3:0] wr_index,
  input wire [1:0] wr_size,
  input wire [4:0] exc_mode,
  input wire [31:0] wr_data, pc_next,
  // state
  input wire [31:0] current_status_word, saved_status_word, pc_value,
  input wire privileged, mode_valid, has_saved_status
);
  // mode field of the live status word
  wire [4:0] mode = current_status_word[4:0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_priv_mode: assert property (privileged == (mode != `BRF_MODE_USER))
    else $error("privileged flag wrong");
  a_saved_exists: assert property (has_saved_status ==
    (mode inside {5'h11, 5'h12, 5'h13, 5'h17, 5'h1b}))
    else $error("saved word presence wrong");
  a_mode_known: assert property (mode_valid == (mode inside
    {5'h10, 5'h11, 5'h12, 5'h13, 5'h17, 5'h1b, 5'h1f}))
    else $error("mode valid flag wrong");
  a_word_mask: assert property (!(current_status_word & ~`BRF_SW_MASK))
    else $error("unused status bits set");
  a_exc_entry: assert property (exc_enter |=> mode == $past(exc_mode)
    && current_status_word[7] && !current_status_word[5])
    else $error("exception entry word wrong");
  a_exc_save: assert property (exc_enter ##1 !exc_enter |=>
    saved_status_word == $past(current_status_word, 2))
    else $error("prior word not saved");
  a_pc_load: assert property (pc_load && !(wr_en && wr_index == 4'hf)
    |=> pc_value == $past(pc_next))
    else $error("pc load lost");
  a_pc_write: assert property (wr_en && wr_index == 4'hf && wr_size == 2'h2
    |=> pc_value == $past(wr_data))
    else $error("pc write lost");
  a_no_saved: assert property (!has_saved_status
    && !$past(has_saved_status) |-> saved_status_word == 32'h0000_0000)
    else $error("saved word seen without bank");
endmodule
bind brf_register_file brf_checker u_chk (.*);

// ==== sim/brf_dp_model.sv ====
// datapath and exception side model driving the register file
// assumes requests start right after a rising edge of core_clk
`timescale 1ns/10ps
module brf_dp_model (
  // clock and read data
  input wire logic core_clk,
  input wire logic [31:0] rd_a_data, rd_b_data,
  // requests toward the file
  output logic [3:0] rd_a_index, rd_b_index, wr_index, sw_wr_field_mask,
  output logic [31:0] wr_data, link_addr, pc_next, sw_wr_data,
  output logic [1:0] wr_size,
  output logic [4:0] exc_mode,
  output logic wr_en, link_en, pc_load, sw_wr_en, sw_wr_saved,
  output logic exc_enter, exc_return
);
  // everything idle at time zero
  initial {rd_a_index, rd_b_index, wr_index, sw_wr_field_mask, wr_data,
    link_addr, pc_next, sw_wr_data, wr_size, exc_mode, wr_en, link_en,
    pc_load, sw_wr_en, sw_wr_saved, exc_enter, exc_return} = '0;
  // let the updates of one more edge land
  task settle;
    @(posedge core_clk);
    #1;
  endtask
  // narrow data sits in the low lanes, as aligned loads deliver it
  task wr(input [3:0] i, input [1:0] s, input [31:0] d);
    @(posedge core_clk);
    {wr_en, wr_index, wr_size, wr_data} <= {1'b1, i, s, d};
    @(posedge core_clk);
    wr_en <= 1'b0;
    settle;
  endtask
  // software write of the live or saved word
  task sw(input sv, input [3:0] m, input [31:0] d);
    @(posedge core_clk);
    {sw_wr_en, sw_wr_saved, sw_wr_field_mask, sw_wr_data} <= {1'b1, sv, m, d};
    @(posedge core_clk);
    sw_wr_en <= 1'b0;
    settle;
  endtask
  // k: return, exception entry, pc load, call with link
  task strobe(input [3:0] k, input [31:0] v, input [4:0] m);
    @(posedge core_clk);
    {exc_return, exc_enter, pc_load, link_en} <= k;
    {link_addr, pc_next, exc_mode} <= {v, v, m};
    @(posedge core_clk);
    {exc_return, exc_enter, pc_load, link_en} <= 4'h0;
    settle;
  endtask
  // read index i on port a and the pc on port b
  task rd(input [3:0] i, output [31:0] a, output [31:0] b);
    @(posedge core_clk);
    {rd_a_index, rd_b_index} <= {i, 4'hf};
    settle;
    {a, b} = {rd_a_data, rd_b_data};
  endtask
endmodule

// ==== sim/tb.sv ====
// self-checking bench for the banked register file
// assumes the datapath model supplies all requests
`timescale 1ns/10ps
`include "brf_map.vh"
module tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] rd_a_index, rd_b_index, wr_index, sw_wr_field_mask;
  logic [31:0] rd_a_data, rd_b_data, wr_data, link_addr, pc_next;
  logic [31:0] sw_wr_data, current_status_word, saved_status_word, pc_value;
  logic [1:0] wr_size;
  logic [4:0] exc_mode;
  logic wr_en, link_en, pc_load, sw_wr_en, sw_wr_saved;
  logic exc_enter, exc_return, privileged, mode_valid, has_saved_status;
  logic [31:0] ra, rb;
  logic [4:0] modes [0:4] = '{5'h12, 5'h13, 5'h17, 5'h1b, 5'h1f};
  int mismatches = 0;
  int compares = 0;
  brf_register_file u_dut (.*);
  brf_dp_model u_dp (.*);
  // 125 MHz clock
  always #4 core_clk = ~core_clk;
  task check(input string n, input [31:0] got, input [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // user view of indices lo..14 after the supervisor fill
  task user_view(input int lo);
    for (int i = lo; i < 15; i++) begin
      u_dp.rd(i[3:0], ra, rb);
      check("user reg", ra, i > 12 ? 32'h0 : 32'ha000_0000 + i);
    end
  endtask
  task t_shared;
    for (int i = 0; i < 15; i++)
      u_dp.wr(i[3:0], `BRF_SIZE_WORD, 32'ha000_0000 + i);
    u_dp.sw(1'b0, 4'h1, 32'h0000_00d0);
    check("priv", privileged, 1'b0);
    user_view(0);
    u_dp.sw(1'b0, 4'h1, 32'h0000_00d3);
    check("refused", current_status_word, 32'h0000_00d0);
    $display("test shared done");
  endtask
  task t_fast;
    u_dp.strobe(4'h4, 32'h0, `BRF_MODE_FAST);
    check("fast word", current_status_word, 32'h0000_00d1);
    check("fast saved", saved_status_word, 32'h0000_00d0);
    for (int i = 8; i < 15; i++)
      u_dp.wr(i[3:0], `BRF_SIZE_WORD, 32'hb000_0000 + i);
    for (int i = 0; i < 15; i++) begin
      u_dp.rd(i[3:0], ra, rb);
      check("fast reg", ra, (i > 7 ? 32'hb000_0000 : 32'ha000_0000) + i);
    end
    u_dp.strobe(4'h8, 32'h0, 5'h00);
    check("return", current_status_word, 32'h0000_00d0);
    user_view(8);
    $display("test fast done");
  endtask
  task t_banks;
    u_dp.strobe(4'h4, 32'h0, `BRF_MODE_IRQ);
    for (int k = 0; k < 5; k++) begin
      u_dp.sw(1'b0, 4'h1, 32'h0000_00c0 | modes[k]);
      u_dp.wr(4'hd, `BRF_SIZE_WORD, 32'hc000_0000 + k);
      u_dp.strobe(4'h1, 32'hd000_0000 + k, 5'h00);
    end
    for (int k = 0; k < 5; k++) begin
      u_dp.sw(1'b0, 4'h1, 32'h0000_00c0 | modes[k]);
      u_dp.rd(4'hd, ra, rb);
      check("stack", ra, 32'hc000_0000 + k);
      u_dp.rd(4'he, ra, rb);
      check("link", ra, 32'hd000_0000 + k);
      check("has saved", has_saved_status, k < 4);
    end
    u_dp.sw(1'b1, 4'h9, 32'hf000_00ff);
    check("sys saved", saved_status_word, 32'h0);
    u_dp.sw(1'b0, 4'h1, 32'h0000_00c0);
    check("bad mode", mode_valid, 1'b0);
    check("bad saved", has_saved_status, 1'b0);
    u_dp.sw(1'b0, 4'h1, 32'h0000_00d3);
    u_dp.sw(1'b1, 4'h9, 32'h5a5a_00d0);
    check("svc saved", saved_status_word, 32'h5000_00d0);
    u_dp.strobe(4'h8, 32'h0, 5'h00);
    check("svc return", current_status_word, 32'h5000_00d0);
    u_dp.rd(4'hd, ra, rb);
    check("sys is user", ra, 32'hc000_0004);
    $display("test banks done");
  endtask
  task t_size_pc;
    u_dp.wr(4'h1, `BRF_SIZE_BYTE, 32'h1234_5678);
    u_dp.wr(4'h2, `BRF_SIZE_HALF, 32'h1234_5678);
    u_dp.rd(4'h1, ra, rb);
    check("byte", ra, 32'h0000_0078);
    u_dp.rd(4'h2, ra, rb);
    check("half", ra, 32'h0000_5678);
    u_dp.sw(1'b0, 4'h8, 32'ha0ff_ffff);
    check("flags", current_status_word, 32'ha000_00d0);
    u_dp.strobe(4'h2, 32'h0000_0100, 5'h00);
    check("pc load", pc_value, 32'h0000_0100);
    u_dp.wr(4'hf, `BRF_SIZE_WORD, 32'h0000_0200);
    u_dp.rd(4'h3, ra, rb);
    check("pc read", rb, 32'h0000_0200);
    $display("test size and pc done");
  endtask
  // reset in mid-run clears storage and restores the reset word
  task t_reset;
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    check("rerun word", current_status_word, `BRF_SW_RESET);
    check("rerun pc", pc_value, 32'h0);
    u_dp.rd(4'h1, ra, rb);
    check("rerun reg", ra, 32'h0);
    check("rerun saved", saved_status_word, 32'h0);
    $display("test reset done");
  endtask
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    mismatches++;
    stop_test;
  end
  // main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    check("reset word", current_status_word, `BRF_SW_RESET);
    check("reset priv", privileged, 1'b1);
    t_shared;
    t_fast;
    t_banks;
    t_size_pc;
    t_reset;
    stop_test;
  end
endmodule
